// >>> common/rdps_pkg.sv
// constants, field layouts and carrier types of the reset and debug pin select block
// assumes a single 125 MHz clock domain and an Avalon-MM register port
package rdps_pkg;

  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 32;
  localparam int          NPIN              = 2;

  // register byte addresses
  localparam logic [7:0]  OFS_SYS_OPT_ONE   = 8'h00;
  localparam logic [7:0]  OFS_PORT_DATA     = 8'h04;
  localparam logic [7:0]  OFS_PORT_DIR      = 8'h08;
  localparam logic [7:0]  OFS_SLEW_EN       = 8'h0C;
  localparam logic [7:0]  OFS_CLK_CTRL      = 8'h10;
  localparam logic [7:0]  OFS_STATUS        = 8'h14;

  // system_options_one fields
  localparam int          BIT_RST_PIN_EN    = 0;
  localparam int          BIT_DBG_PIN_EN    = 1;
  // port bit positions inside port and slew registers
  localparam int          BIT_PORT_FOUR     = 0;
  localparam int          BIT_PORT_FIVE     = 1;
  // status fields
  localparam int          BIT_ST_RST_ROLE   = 0;
  localparam int          BIT_ST_BG_MODE    = 1;
  localparam int          BIT_ST_PIN_RST    = 2;
  localparam int          BIT_ST_DBG_ACT    = 3;
  localparam int          BIT_ST_CAP_ROUTE  = 4;

  // clock defaults: 16 MHz internal reference, bus divided by 4
  localparam int          MCLK_HZ           = 125_000_000;
  localparam int          INT_CLK_HZ        = 16_000_000;
  localparam int          INT_TICK_DIV      = MCLK_HZ / INT_CLK_HZ;
  localparam int          BUS_DIV_W         = 2;
  localparam logic [1:0]  BUS_DIV_RST       = 2'h2;
  localparam int          DBG_CLK_PER_BIT   = 16;

  // internal reset stretch
  localparam int          RST_HOLD_NS       = 64;
  localparam int          MCLK_PERIOD_PS    = 1_000_000_000 / (MCLK_HZ / 1000);
  localparam int          RST_HOLD_CYC      = (RST_HOLD_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;

  localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;
  localparam logic [31:0] RD_ZERO           = 32'h0000_0000;

  typedef enum logic {RDPS_RS_HOLD, RDPS_RS_RUN} rdps_rst_state_t;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
  } rdps_av_req_t;

  typedef struct packed {
    logic out;
    logic oe_n;
    logic pull_en;
    logic slew_en;
  } rdps_pin_drv_t;

endpackage

// >>> rtl/rdps_sync2.sv
// two-flop synchroniser for levels arriving from pins
// assumes the destination runs on mclk; reset value is a parameter
`timescale 1ns/100ps
module rdps_sync2
  import rdps_pkg::*;
#(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '1
)(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end
    else if (clk_en)
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // rdps_sync2

// >>> rtl/rdps_tick_div.sv
// tick divider: one pulse every limit+1 steps
// assumes step and limit come from mclk logic
`timescale 1ns/100ps
module rdps_tick_div
  import rdps_pkg::*;
#(
  parameter int W = 8
)(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic         clr,
  input  wire logic         step,
  input  wire logic [W-1:0] limit,
  output logic              tick
);

  logic [W-1:0] cnt_q;
  wire          wrap = step && (cnt_q >= limit);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end
    else if (clk_en)
    begin
      tick <= wrap && !clr;
      if (clr || wrap)
        cnt_q <= '0;
      else if (step)
        cnt_q <= cnt_q + W'(1);
    end
  end

endmodule // rdps_tick_div

// >>> rtl/rdps_top.sv
// reset and debug pin select: owns the shared reset pin (port bit five)
// and the debug/mode-select pin (port bit four), their pullups, slew bits,
// the reset stretch, mode sampling and default clock ratios
// assumes pins arrive unsynchronised; timer and debug controller share mclk
`timescale 1ns/100ps
module rdps_top
  import rdps_pkg::*;
#(
  parameter int DBG_DIV_W  = 4,
  parameter int INT_DIV_W  = 4,
  parameter int HOLD_CYC   = RST_HOLD_CYC
)(
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic               clk_en,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]  avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [DATA_W-1:0]  avs_writedata,
  output logic      [DATA_W-1:0]  avs_readdata,
  output logic                    avs_waitrequest,
  // other reset sources on mclk
  input  wire logic               sys_reset_req,
  input  wire logic               dbg_force_reset,
  // shared reset pin
  input  wire logic               port_a_bit_five_in,
  output rdps_pin_drv_t           port_a_bit_five_drv,
  // debug / mode select pin
  input  wire logic               port_a_bit_four_in,
  output rdps_pin_drv_t           port_a_bit_four_drv,
  // second timer
  input  wire logic               timer_capture_mode,
  input  wire logic               timer_two_compare_output,
  input  wire logic               timer_compare_drive,
  output logic                    timer_two_capture_input,
  // debug controller
  input  wire logic               dbg_tx_drive,
  input  wire logic               dbg_tx_level,
  output logic                    dbg_rx_level,
  output logic                    dbg_link_active,
  output logic                    dbg_bit_tick,
  // core side
  output logic                    core_reset_n,
  output logic                    background_mode,
  output logic      [15:0]        reset_vector_addr,
  output logic                    bus_tick
);

  // ---------------- pin synchronisers ----------------
  logic [1:0] pins_s;

  rdps_sync2 #(
    .W       (2),
    .RST_VAL (2'h3)
  ) u_pin_sync (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .d      ({port_a_bit_five_in, port_a_bit_four_in}),
    .q      (pins_s)
  );

  wire pin_five_s = pins_s[1];
  wire pin_four_s = pins_s[0];

  // ---------------- control state ----------------
  logic            reset_role_q;
  logic            debug_pin_enable_q;
  logic [1:0]      port_out_q;
  logic            port_four_dir_q;
  logic [NPIN-1:0] slew_enable_bits_q;
  logic [1:0]      bus_div_q;
  logic            bg_mode_q;
  logic            pin_reset_seen_q;
  logic            sample_mode_q;
  rdps_rst_state_t rst_state_q;
  logic [7:0]      hold_cnt_q;

  // ---------------- bus decode ----------------
  rdps_av_req_t req;
  logic         ack_q;

  assign req = '{read: avs_read, write: avs_write, address: avs_address, writedata: avs_writedata};

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // a request is taken once; waitrequest drops for the single following cycle
  // writes land at the edge where the master sees waitrequest low, not before
  wire take      = (req.read || req.write) && !ack_q;
  wire wr_take   = ack_q && req.write;
  wire wr_opt    = wr_take && hit(req.address, OFS_SYS_OPT_ONE);
  wire wr_data   = wr_take && hit(req.address, OFS_PORT_DATA);
  wire wr_dir    = wr_take && hit(req.address, OFS_PORT_DIR);
  wire wr_slew   = wr_take && hit(req.address, OFS_SLEW_EN);
  wire wr_clk    = wr_take && hit(req.address, OFS_CLK_CTRL);

  // ---------------- reset sequencing ----------------
  wire in_reset       = (rst_state_q == RDPS_RS_HOLD);
  wire ext_pin_reset  = reset_role_q && !pin_five_s;
  wire any_reset_req  = ext_pin_reset || sys_reset_req || dbg_force_reset;
  wire hold_done      = (hold_cnt_q == 8'(HOLD_CYC - 1));
  wire release_now    = in_reset && hold_done && !any_reset_req;
  wire mode_low       = !pin_four_s;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_state_q   <= RDPS_RS_HOLD;
      hold_cnt_q    <= '0;
      sample_mode_q <= 1'b1;
      bg_mode_q     <= 1'b0;
    end
    else if (clk_en)
    begin
      case (rst_state_q)
        RDPS_RS_HOLD:
        begin
          if (any_reset_req)
            hold_cnt_q <= '0;
          else if (!hold_done)
            hold_cnt_q <= hold_cnt_q + 8'h01;
          if (dbg_force_reset)
            sample_mode_q <= 1'b1;
          if (release_now)
          begin
            rst_state_q   <= RDPS_RS_RUN;
            sample_mode_q <= 1'b0;
            // mode pin read at the rising edge of internal reset, only after a power-on or debug-forced reset
            if (sample_mode_q)
              bg_mode_q <= mode_low;
          end
        end
        RDPS_RS_RUN:
        begin
          if (any_reset_req)
          begin
            rst_state_q   <= RDPS_RS_HOLD;
            hold_cnt_q    <= '0;
            sample_mode_q <= dbg_force_reset;
          end
        end
        default:
        begin
          rst_state_q <= RDPS_RS_HOLD;
          hold_cnt_q  <= '0;
        end
      endcase
    end
  end

  // a power-on into background mode claims the reset role at release
  wire bg_por_release = release_now && sample_mode_q && mode_low && !reset_role_q;

  // reset role: only the asynchronous power-on reset clears it
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      reset_role_q <= 1'b0;
    else if (clk_en)
    begin
      if (bg_por_release)
        reset_role_q <= 1'b1;
      else if (!in_reset && wr_opt && req.writedata[BIT_RST_PIN_EN])
        reset_role_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pin_reset_seen_q <= 1'b0;
    else if (clk_en && ext_pin_reset)
      pin_reset_seen_q <= 1'b1;
    else if (clk_en && (sys_reset_req || dbg_force_reset))
      pin_reset_seen_q <= 1'b0;
  end

  // ---------------- software registers ----------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      debug_pin_enable_q <= 1'b1;
      port_out_q         <= '0;
      port_four_dir_q    <= 1'b0;
      slew_enable_bits_q <= '0;
      bus_div_q          <= BUS_DIV_RST;
    end
    else if (clk_en)
    begin
      if (in_reset)
      begin
        debug_pin_enable_q <= 1'b1;
        port_out_q         <= '0;
        port_four_dir_q    <= 1'b0;
        slew_enable_bits_q <= '0;
        bus_div_q          <= BUS_DIV_RST;
      end
      else
      begin
        if (wr_opt)
          debug_pin_enable_q <= req.writedata[BIT_DBG_PIN_EN];
        if (wr_data)
          port_out_q <= req.writedata[1:0];
        if (wr_dir)
          port_four_dir_q <= req.writedata[BIT_PORT_FOUR];
        if (wr_slew)
          slew_enable_bits_q <= req.writedata[NPIN-1:0];
        if (wr_clk)
          bus_div_q <= req.writedata[BUS_DIV_W-1:0];
      end
    end
  end

  // ---------------- pin function selection ----------------
  wire dbg_role       = debug_pin_enable_q;
  wire cap_route      = timer_capture_mode && !reset_role_q;
  wire four_is_timer  = !dbg_role && timer_compare_drive;
  wire four_is_port   = !dbg_role && !timer_compare_drive && port_four_dir_q;
  // debug drive is held off during reset so the mode level can be sampled
  wire four_dbg_drive = dbg_role && !in_reset && dbg_tx_drive;
  wire four_drives    = four_dbg_drive || four_is_timer || four_is_port;
  wire four_level     = four_dbg_drive ? dbg_tx_level :
                        four_is_timer  ? timer_two_compare_output : port_out_q[BIT_PORT_FOUR];
  // the shared reset pin is input only
  wire five_in_port   = reset_role_q ? 1'b0 : pin_five_s;
  wire four_in_port   = dbg_role ? 1'b0 : pin_four_s;

  rdps_pin_drv_t five_d;
  rdps_pin_drv_t four_d;

  assign five_d = '{out: 1'b0, oe_n: 1'b1, pull_en: reset_role_q,
                    slew_en: 1'b0};
  assign four_d = '{out: four_level, oe_n: !four_drives, pull_en: dbg_role,
                    slew_en: four_drives && slew_enable_bits_q[BIT_PORT_FOUR]};

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_a_bit_five_drv     <= '{out: 1'b0, oe_n: 1'b1, pull_en: 1'b0, slew_en: 1'b0};
      port_a_bit_four_drv     <= '{out: 1'b0, oe_n: 1'b1, pull_en: 1'b1, slew_en: 1'b0};
      timer_two_capture_input <= 1'b0;
      dbg_rx_level            <= 1'b1;
      dbg_link_active         <= 1'b0;
    end
    else if (clk_en)
    begin
      port_a_bit_five_drv     <= five_d;
      port_a_bit_four_drv     <= four_d;
      timer_two_capture_input <= cap_route ? pin_five_s : 1'b0;
      dbg_rx_level            <= dbg_role ? pin_four_s : 1'b1;
      dbg_link_active         <= dbg_role && !in_reset;
    end
  end

  // ---------------- clock ratios and debug bit timing ----------------
  logic int_tick;
  logic bus_tick_w;
  logic bit_tick_w;

  rdps_tick_div #(
    .W (INT_DIV_W)
  ) u_int_div (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .clr    (1'b0),
    .step   (1'b1),
    .limit  (INT_DIV_W'(INT_TICK_DIV - 1)),
    .tick   (int_tick)
  );

  wire [3:0] bus_limit = (4'h1 << bus_div_q) - 4'h1;

  rdps_tick_div #(
    .W (4)
  ) u_bus_div (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .clr    (in_reset),
    .step   (int_tick),
    .limit  (bus_limit),
    .tick   (bus_tick_w)
  );

  // debug clock runs at bus rate; one bit per sixteen debug clocks
  rdps_tick_div #(
    .W (DBG_DIV_W)
  ) u_bit_div (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .clr    (!dbg_role || in_reset),
    .step   (bus_tick_w),
    .limit  (DBG_DIV_W'(DBG_CLK_PER_BIT - 1)),
    .tick   (bit_tick_w)
  );

  // ---------------- core side ----------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_reset_n      <= 1'b0;
      background_mode   <= 1'b0;
      reset_vector_addr <= RESET_VECTOR_ADDR;
      bus_tick          <= 1'b0;
      dbg_bit_tick      <= 1'b0;
    end
    else if (clk_en)
    begin
      core_reset_n      <= !in_reset;
      background_mode   <= bg_mode_q;
      reset_vector_addr <= RESET_VECTOR_ADDR;
      bus_tick          <= bus_tick_w;
      dbg_bit_tick      <= bit_tick_w && dbg_role;
    end
  end

  // ---------------- read path ----------------
  logic [DATA_W-1:0] rd_mux;

  always_comb
  begin
    rd_mux = RD_ZERO;
    if (hit(req.address, OFS_SYS_OPT_ONE))
    begin
      rd_mux[BIT_RST_PIN_EN] = reset_role_q;
      rd_mux[BIT_DBG_PIN_EN] = debug_pin_enable_q;
    end
    else if (hit(req.address, OFS_PORT_DATA))
    begin
      rd_mux[BIT_PORT_FOUR] = port_four_dir_q ? port_out_q[BIT_PORT_FOUR] : four_in_port;
      rd_mux[BIT_PORT_FIVE] = five_in_port;
    end
    else if (hit(req.address, OFS_PORT_DIR))
      rd_mux[BIT_PORT_FOUR] = port_four_dir_q;
    else if (hit(req.address, OFS_SLEW_EN))
      rd_mux[NPIN-1:0] = slew_enable_bits_q;
    else if (hit(req.address, OFS_CLK_CTRL))
      rd_mux[BUS_DIV_W-1:0] = bus_div_q;
    else if (hit(req.address, OFS_STATUS))
    begin
      rd_mux[BIT_ST_RST_ROLE]  = reset_role_q;
      rd_mux[BIT_ST_BG_MODE]   = bg_mode_q;
      rd_mux[BIT_ST_PIN_RST]   = pin_reset_seen_q;
      rd_mux[BIT_ST_DBG_ACT]   = dbg_role && !in_reset;
      rd_mux[BIT_ST_CAP_ROUTE] = cap_route;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_q           <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= RD_ZERO;
    end
    else if (clk_en)
    begin
      ack_q           <= take;
      avs_waitrequest <= !take;
      if (take && req.read)
        avs_readdata <= rd_mux;
    end
  end

endmodule // rdps_top

// >>> tb/rdps_pin_model.sv
// far side of the two shared pins: external reset source and debug pod
// assumes the bench commands it with levels changed just after mclk edges
`timescale 1ns/100ps
module rdps_pin_model
  import rdps_pkg::*;
(
  input  logic          mclk,
  input  logic          pod_low,
  input  logic          src_drive,
  input  logic          src_level,
  input  rdps_pin_drv_t four_drv,
  input  rdps_pin_drv_t five_drv,
  output logic          pin_four,
  output logic          pin_five
);
  logic four_last_q = 1'b1;
  logic five_last_q = 1'b1;

  // an undriven line with no pullup wanders, so show the inverse of its last level
  assign pin_four = !four_drv.oe_n ? four_drv.out : pod_low ? 1'b0 : four_drv.pull_en ? 1'b1 : ~four_last_q;
  assign pin_five = src_drive ? src_level : five_drv.pull_en ? 1'b1 : ~five_last_q;

  always @(posedge mclk)
  begin
    four_last_q <= pin_four;
    five_last_q <= pin_five;
  end
endmodule // rdps_pin_model

// >>> tb/rdps_top_chk.sv
// port-level checker for rdps_top
// assumes one mclk domain with rst_n as the power-on reset
`timescale 1ns/100ps
module rdps_top_chk
  import rdps_pkg::*;
(
  input logic          mclk,
  input logic          rst_n,
  input logic          port_a_bit_five_in,
  input rdps_pin_drv_t port_a_bit_five_drv,
  input rdps_pin_drv_t port_a_bit_four_drv,
  input logic          timer_capture_mode,
  input logic          timer_two_capture_input,
  input logic          dbg_rx_level,
  input logic          dbg_link_active,
  input logic          core_reset_n,
  input logic [15:0]   reset_vector_addr,
  input logic          bus_tick
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  wire five_role = port_a_bit_five_drv.pull_en;

  sequence s_pin_low; (five_role && !port_a_bit_five_in) [*3]; endsequence
  sequence s_core_rst; ##[0:4] !core_reset_n; endsequence
  property p_pin_rst; s_pin_low |-> s_core_rst; endproperty
  property p_cap_src; timer_two_capture_input |-> $past(timer_capture_mode); endproperty
  property p_cap_mask; five_role [*2] |-> !timer_two_capture_input; endproperty
  property p_dbg_pull; dbg_link_active [*2] |-> port_a_bit_four_drv.pull_en; endproperty
  property p_rx_idle; !port_a_bit_four_drv.pull_en [*2] |-> dbg_rx_level; endproperty
  property p_rst_dbg; $rose(core_reset_n) |-> port_a_bit_four_drv.pull_en; endproperty
  property p_role_hold; five_role |=> five_role; endproperty
  property p_slew_in;
    !(port_a_bit_five_drv.slew_en || (port_a_bit_four_drv.oe_n && port_a_bit_four_drv.slew_en));
  endproperty
  // internal resets restart the bus and bit dividers, so the period is only judged between them
  property p_bus_div;
    disable iff (!rst_n || !core_reset_n) bus_tick |=> !bus_tick [*8] ##20 bus_tick;
  endproperty
  property p_vector; core_reset_n |-> reset_vector_addr == 16'hFFFE; endproperty

  a_pin_rst: assert property (p_pin_rst)
    else $error("reset pin low did not reset the core");
  a_cap_src: assert property (p_cap_src)
    else $error("capture input without capture mode");
  a_cap_mask: assert property (p_cap_mask)
    else $error("capture input passed in reset role");
  a_dbg_pull: assert property (p_dbg_pull)
    else $error("debug pin pullup off while link active");
  a_rx_idle: assert property (p_rx_idle)
    else $error("debug receive not idle outside debug role");
  a_rst_dbg: assert property (p_rst_dbg)
    else $error("debug pin enable not set after reset");
  a_role_hold: assert property (p_role_hold)
    else $error("reset role dropped without power-on");
  a_slew_in: assert property (p_slew_in)
    else $error("slew enabled on an input pin");
  a_bus_div: assert property (p_bus_div)
    else $error("bus tick period wrong");
  a_vector: assert property (p_vector)
    else $error("reset vector address wrong");
endmodule // rdps_top_chk

bind rdps_top rdps_top_chk u_chk (
  .mclk                    (mclk),
  .rst_n                   (rst_n),
  .port_a_bit_five_in      (port_a_bit_five_in),
  .port_a_bit_five_drv     (port_a_bit_five_drv),
  .port_a_bit_four_drv     (port_a_bit_four_drv),
  .timer_capture_mode      (timer_capture_mode),
  .timer_two_capture_input (timer_two_capture_input),
  .dbg_rx_level            (dbg_rx_level),
  .dbg_link_active         (dbg_link_active),
  .core_reset_n            (core_reset_n),
  .reset_vector_addr       (reset_vector_addr),
  .bus_tick                (bus_tick)
);

// >>> tb/rdps_top_tb.sv
// self-checking bench for rdps_top: bus tasks, pin stimulus, reset scenarios
// assumes rdps_pin_model on the pins and the bound checker
`timescale 1ns/100ps
module rdps_top_tb
  import rdps_pkg::*;
;
  logic              mclk            = 1'b0;
  logic              rst_n           = 1'b0;
  logic [ADDR_W-1:0] avs_address     = '0;
  logic              avs_read        = 1'b0;
  logic              avs_write       = 1'b0;
  logic [DATA_W-1:0] avs_writedata   = '0;
  logic              sys_reset_req   = 1'b0;
  logic              dbg_force_reset = 1'b0;
  logic              cap_mode        = 1'b0;
  logic              pod_low         = 1'b0;
  logic              src_drive       = 1'b1;
  logic              src_level       = 1'b1;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              pin_four;
  logic              pin_five;
  rdps_pin_drv_t     five_drv;
  rdps_pin_drv_t     four_drv;
  logic              cap_in;
  logic              rx_lvl;
  logic              link_act;
  logic              bit_tick;
  logic              core_rst_n;
  logic              bg_mode;
  logic [15:0]       vec_addr;
  logic              bus_tick;
  logic [DATA_W-1:0] rd;
  int                bad_count       = 0;
  int                checked         = 0;
  int                n;

  always #4 mclk = ~mclk;

  rdps_top u_dut (
    .mclk(mclk), .rst_n(rst_n), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sys_reset_req(sys_reset_req), .dbg_force_reset(dbg_force_reset),
    .port_a_bit_five_in(pin_five), .port_a_bit_five_drv(five_drv),
    .port_a_bit_four_in(pin_four), .port_a_bit_four_drv(four_drv),
    .timer_capture_mode(cap_mode), .timer_two_compare_output(1'b0), .timer_compare_drive(1'b0),
    .timer_two_capture_input(cap_in), .dbg_tx_drive(1'b0), .dbg_tx_level(1'b1),
    .dbg_rx_level(rx_lvl), .dbg_link_active(link_act), .dbg_bit_tick(bit_tick),
    .core_reset_n(core_rst_n), .background_mode(bg_mode), .reset_vector_addr(vec_addr),
    .bus_tick(bus_tick)
  );

  rdps_pin_model u_far (
    .mclk(mclk), .pod_low(pod_low), .src_drive(src_drive), .src_level(src_level),
    .four_drv(four_drv), .five_drv(five_drv), .pin_four(pin_four), .pin_five(pin_five)
  );

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
    int k;
    k = 0;
    @(posedge mclk);
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_address   <= a;
    avs_writedata <= wd;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 100);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (k >= 100)
      bad_count++;
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    bus(1'b0, a, '0);
    chk(rd, exp);
  endtask

  task automatic wait_core(input logic v);
    int k;
    k = 0;
    while (core_rst_n !== v && k < 200)
    begin
      @(posedge mclk);
      k++;
    end
    if (k >= 200)
      bad_count++;
  endtask

  task automatic por(input logic low);
    pod_low <= low;
    rst_n   <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    wait_core(1'b1);
    pod_low <= 1'b0;
  endtask

  task automatic pulse(input logic frc);
    dbg_force_reset <= frc;
    sys_reset_req   <= !frc;
    @(posedge mclk);
    dbg_force_reset <= 1'b0;
    sys_reset_req   <= 1'b0;
    wait_core(1'b0);
    wait_core(1'b1);
  endtask

  task automatic settle();
    repeat (5) @(posedge mclk);
  endtask

  task automatic print_verdict();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    por(1'b1);
    chk(bg_mode, 1'b1);
    chk(five_drv.pull_en, 1'b1);
    por(1'b0);
    chk(bg_mode, 1'b0);
    chk(five_drv.pull_en, 1'b0);
    rchk(OFS_SYS_OPT_ONE, 32'h0000_0002);
    chk(vec_addr, 16'hFFFE);
    chk(link_act, 1'b1);
    rchk(OFS_CLK_CTRL, 32'h0000_0002);
    rchk(8'h20, 32'h0000_0000);
    src_level <= 1'b0;
    settle();
    rchk(OFS_PORT_DATA, 32'h0000_0000);
    src_level <= 1'b1;
    cap_mode  <= 1'b1;
    settle();
    rchk(OFS_PORT_DATA, 32'h0000_0002);
    chk(cap_in, 1'b1);
    rchk(OFS_STATUS, 32'h0000_0018);
    n = 0;
    while (bit_tick !== 1'b1 && n < 1000)
    begin
      @(posedge mclk);
      n++;
    end
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (bit_tick !== 1'b1 && n < 1000);
    chk(n, DBG_CLK_PER_BIT * 4 * INT_TICK_DIV);
    bus(1'b1, OFS_SYS_OPT_ONE, 32'h0000_0000);
    settle();
    chk(link_act, 1'b0);
    chk(four_drv.pull_en, 1'b0);
    rchk(OFS_SYS_OPT_ONE, 32'h0000_0000);
    bus(1'b1, OFS_PORT_DIR, 32'h0000_0001);
    bus(1'b1, OFS_PORT_DATA, 32'h0000_0001);
    bus(1'b1, OFS_SLEW_EN, 32'h0000_0003);
    settle();
    chk(four_drv, 4'h9);
    chk(five_drv.slew_en, 1'b0);
    bus(1'b1, OFS_PORT_DIR, 32'h0000_0000);
    settle();
    chk(four_drv.slew_en, 1'b0);
    bus(1'b1, OFS_SYS_OPT_ONE, 32'h0000_0001);
    // let go of the pin only once the pullup holds it, else it toggles every cycle
    settle();
    src_drive <= 1'b0;
    settle();
    chk(five_drv.pull_en, 1'b1);
    chk(pin_five, 1'b1);
    chk(cap_in, 1'b0);
    rchk(OFS_STATUS, 32'h0000_0001);
    cap_mode <= 1'b0;
    bus(1'b1, OFS_SYS_OPT_ONE, 32'h0000_0000);
    rchk(OFS_SYS_OPT_ONE, 32'h0000_0001);
    pulse(1'b0);
    rchk(OFS_SYS_OPT_ONE, 32'h0000_0003);
    src_drive <= 1'b1;
    src_level <= 1'b0;
    wait_core(1'b0);
    settle();
    chk(core_rst_n, 1'b0);
    src_level <= 1'b1;
    wait_core(1'b1);
    rchk(OFS_STATUS, 32'h0000_000D);
    pod_low <= 1'b1;
    pulse(1'b1);
    chk(bg_mode, 1'b1);
    pod_low <= 1'b0;
    pulse(1'b1);
    chk(bg_mode, 1'b0);
    por(1'b0);
    chk(five_drv.pull_en, 1'b0);
    print_verdict();
  end

  // the sequence needs roughly a thousand cycles; this bound is over ten times that
  initial
  begin
    #100_000;
    bad_count++;
    print_verdict();
  end
endmodule // rdps_top_tb
